// ### src/ppw_pkg.sv
package ppw_pkg;
	// ******************************
	// widths and constants
	// ******************************
	localparam int CNT_W = 16;
	localparam logic [15:0] CNT_ZERO = 16'h0000;
	localparam logic [15:0] CNT_ONE = 16'h0001;
	localparam logic [15:0] CNT_MAX = 16'hffff;
	localparam logic [1:0] SRC_F1 = 2'h0;
	localparam logic [1:0] SRC_F8 = 2'h1;
	localparam logic [1:0] SRC_F32 = 2'h2;
	localparam logic [1:0] SRC_FC32 = 2'h3;
	localparam logic [4:0] DIV_1 = 5'h00;
	localparam logic [4:0] DIV_8 = 5'h07;
	localparam logic [4:0] DIV_32 = 5'h1f;

	// measurement selection
	typedef enum logic [1:0] {
		PPW_PER_FALL,
		PPW_PER_RISE,
		PPW_WIDTH,
		PPW_RSVD
	} ppw_meas_t;

	// status bundle seen by software
	typedef struct packed {
		logic [15:0] result;
		logic ovf_flag;
		logic irq_req;
	} ppw_stat_t;
endpackage

// ### src/ppw_capture.sv
`timescale 1ns/1ps
// What this block does
// R1: counts up; on effective edge latches count into reload, restarts from zero
// R2: counts only while count start flag is one
// R3: effective edge while counting raises interrupt request
// R4: first effective edge after start gives no interrupt, only reference
// R5: overflow raises interrupt and sets overflow flag same cycle
// R6: overflow flag clears only on mode write while start flag is one
// R7: timer read returns latched reload value, not live count
// R8: result not a valid measurement before second effective edge; reload cleared to zero at reset
// R9: timer register writes are ignored in this mode
// R10: interrupt bit clears on acceptance or software write
// R11: falling period mode measures falling edge to falling edge
// R12: width mode captures on both edges, alternating high/low
// R13: measured input is synchronised and edge detected first
module ppw_capture (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic count_start,
	input wire logic [1:0] count_src,
	input wire ppw_pkg::ppw_meas_t meas_sel,
	input wire logic fc32_tick,
	input wire logic measure_pulse_input,
	input wire logic mode_wr,
	input wire logic timer_wr,
	input wire logic [15:0] timer_wdata,
	input wire logic irq_ack,
	input wire logic irq_clr_wr,
	output ppw_pkg::ppw_stat_t stat
);
	// ******************************
	// input synchroniser
	// ******************************
	logic sync1_ff, sync2_ff, prev_ff;
	logic nxt_sync1, nxt_sync2, nxt_prev;
	logic rise, fall, eff_edge;

	// R13: two-stage sync then edge detect
	always_comb begin
		nxt_sync1 = measure_pulse_input;
		nxt_sync2 = sync1_ff;
		nxt_prev = sync2_ff;
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			// reset to the pin's idle high level, else a false rise follows reset
			sync1_ff <= 1'b1;
			sync2_ff <= 1'b1;
			prev_ff <= 1'b1;
		end else begin
			sync1_ff <= nxt_sync1;
			sync2_ff <= nxt_sync2;
			prev_ff <= nxt_prev;
		end
	end

	assign rise = sync2_ff & ~prev_ff;
	assign fall = ~sync2_ff & prev_ff;

	// effective edge select
	always_comb begin
		case (meas_sel)
			// R11: falling to falling
			ppw_pkg::PPW_PER_FALL: eff_edge = fall;
			ppw_pkg::PPW_PER_RISE: eff_edge = rise;
			// R12: both polarities
			ppw_pkg::PPW_WIDTH: eff_edge = rise | fall;
			default: eff_edge = 1'b0;
		endcase
	end

	// ******************************
	// prescaler
	// ******************************
	logic [4:0] pre_ff, nxt_pre, pre_top;
	logic tick;

	always_comb begin
		case (count_src)
			ppw_pkg::SRC_F1: pre_top = ppw_pkg::DIV_1;
			ppw_pkg::SRC_F8: pre_top = ppw_pkg::DIV_8;
			ppw_pkg::SRC_F32: pre_top = ppw_pkg::DIV_32;
			default: pre_top = ppw_pkg::DIV_1;
		endcase
		if (count_src == ppw_pkg::SRC_FC32) begin
			tick = count_start & fc32_tick;
		end else begin
			tick = count_start & (pre_ff == pre_top);
		end
		if (!count_start || pre_ff >= pre_top) begin
			nxt_pre = 5'h00;
		end else begin
			nxt_pre = pre_ff + 5'h01;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			pre_ff <= 5'h00;
		end else begin
			pre_ff <= nxt_pre;
		end
	end

	// ******************************
	// counter, reload and flags
	// ******************************
	logic [15:0] cnt_ff, nxt_cnt, reload_ff, nxt_reload;
	logic armed_ff, nxt_armed, ovf_ff, nxt_ovf, irq_ff, nxt_irq;
	logic ovf_evt, edge_evt, unused_wr;

	// R9: writes to timer register discarded
	assign unused_wr = timer_wr ^ (|timer_wdata);

	always_comb begin
		nxt_cnt = cnt_ff;
		// R8: reload holds; cleared at reset so the read is never unknown
		nxt_reload = reload_ff;
		nxt_armed = armed_ff;
		nxt_ovf = ovf_ff;
		nxt_irq = irq_ff;
		edge_evt = count_start & eff_edge;
		// R5: wrap of the up counter
		ovf_evt = tick & ~edge_evt & (cnt_ff == ppw_pkg::CNT_MAX);
		// R2: halt clears arming so next start needs a reference edge
		if (!count_start) begin
			nxt_armed = 1'b0;
		end
		// R1: latch and restart on edge
		if (edge_evt) begin
			nxt_reload = cnt_ff;
			nxt_cnt = ppw_pkg::CNT_ZERO;
			nxt_armed = 1'b1;
		end else if (tick) begin
			nxt_cnt = cnt_ff + ppw_pkg::CNT_ONE;
		end
		// R6: clear on mode write only while running
		if (mode_wr && count_start) begin
			nxt_ovf = 1'b0;
		end
		if (ovf_evt) begin
			nxt_ovf = 1'b1;
		end
		// R10: ack or software clear, set wins
		if (irq_ack || irq_clr_wr) begin
			nxt_irq = 1'b0;
		end
		// R3 R4: edge irq only once armed
		if ((edge_evt && armed_ff) || ovf_evt) begin
			nxt_irq = 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			cnt_ff <= ppw_pkg::CNT_ZERO;
			armed_ff <= 1'b0;
			ovf_ff <= 1'b0;
			irq_ff <= 1'b0;
			reload_ff <= ppw_pkg::CNT_ZERO;
		end else begin
			cnt_ff <= nxt_cnt;
			armed_ff <= nxt_armed;
			ovf_ff <= nxt_ovf;
			irq_ff <= nxt_irq;
			reload_ff <= nxt_reload;
		end
	end

	// R7: read path shows reload register, never the live count
	// one assignment keeps the status bundle single-driven
	assign stat = {reload_ff, ovf_ff, irq_ff};

	// ******************************
	// assertions
	// ******************************
	capture_value_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // R1
		(count_start && eff_edge) |=> (reload_ff == $past(cnt_ff) && cnt_ff == 16'h0000))
		else $error("capture did not latch and restart");
	halt_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // R2
		(!count_start) |=> (cnt_ff == $past(cnt_ff)))
		else $error("counter moved while halted");
	edge_irq_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // R3
		(count_start && eff_edge && armed_ff) |=> irq_ff)
		else $error("edge irq missing");
	first_edge_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // R4
		(count_start && eff_edge && !armed_ff && !irq_ff && !ovf_evt) |=> !irq_ff)
		else $error("first edge raised irq");
	ovf_set_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // R5
		ovf_evt |=> (ovf_ff && irq_ff && cnt_ff == 16'h0000))
		else $error("overflow not flagged");
	ovf_clear_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // R6
		(ovf_ff && !(mode_wr && count_start)) |=> ovf_ff)
		else $error("overflow flag cleared wrongly");
	read_path_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // R7
		edge_evt |=> (stat.result == $past(cnt_ff)))
		else $error("read path not showing captured count");
	write_ignore_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // R9
		(timer_wr && !edge_evt) |=> (reload_ff == $past(reload_ff)))
		else $error("timer write changed the result");
	armed_clear_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // R4
		(!count_start) |=> !armed_ff)
		else $error("reference kept across a stop");
	ovf_clr_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // R6
		(mode_wr && count_start && !ovf_evt) |=> !ovf_ff)
		else $error("overflow flag not cleared by mode write");
	irq_clear_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // R10
		(irq_ack && !edge_evt && !ovf_evt) |=> !irq_ff)
		else $error("irq not cleared on ack");
	width_edge_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // R12
		(meas_sel == ppw_pkg::PPW_WIDTH && count_start && rise) |=> cnt_ff == 16'h0000)
		else $error("width mode missed rising edge");

	// ******************************
	// cover points
	// ******************************
	cap_cov_c: cover property (@(posedge clk_sys) edge_evt && armed_ff);
	width_cov_c: cover property (@(posedge clk_sys) meas_sel == ppw_pkg::PPW_WIDTH && edge_evt);
	clr_cov_c: cover property (@(posedge clk_sys) ovf_ff && mode_wr && count_start);
	ovf_cov_c: cover property (@(posedge clk_sys) ovf_evt);
	ack_cov_c: cover property (@(posedge clk_sys) irq_ff ##1 irq_ack);
endmodule

// ### tb/ppw_pulse_src.sv
`timescale 1ns/1ps
// ****
// far-side pulse source
// ****
module ppw_pulse_src (
	input wire logic clk_sys,
	input wire logic run,
	input wire logic [15:0] hi_len,
	input wire logic [15:0] lo_len,
	output logic measure_pulse_input
);
	int cnt = 0;
	initial measure_pulse_input = 1'b1;
	// idles high; each phase lasts its length in cycles
	always @(negedge clk_sys) begin
		cnt = cnt + 1;
		if (!run) begin
			measure_pulse_input <= 1'b1;
			cnt = 0;
		end else if (cnt >= (measure_pulse_input ? hi_len : lo_len)) begin
			measure_pulse_input <= ~measure_pulse_input;
			cnt = 0;
		end
	end
endmodule

// ### tb/pulse_period_width_capture_tb.sv
`timescale 1ns/1ps
// ****
// bench
// ****
module pulse_period_width_capture_tb;
	logic clk_sys, sys_rst, count_start, mode_wr, timer_wr, irq_ack, irq_clr_wr, run, pin;
	logic [15:0] timer_wdata, hi_len, lo_len, lfsr, keep;
	logic [1:0] src_sel;
	logic fc32;
	int q_len[$];
	int gap = 0;
	logic pin_d = 1'b1;
	ppw_pkg::ppw_meas_t meas_sel;
	ppw_pkg::ppw_stat_t stat;
	int n_fail = 0;
	int cmp_count = 0;
	// f1 or an fc32 tick held high, so results are exact cycle counts
	ppw_capture u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .count_start(count_start),
		.count_src(src_sel), .meas_sel(meas_sel), .fc32_tick(fc32), .measure_pulse_input(pin),
		.mode_wr(mode_wr), .timer_wr(timer_wr), .timer_wdata(timer_wdata),
		.irq_ack(irq_ack), .irq_clr_wr(irq_clr_wr), .stat(stat));
	ppw_pulse_src u_src (.clk_sys(clk_sys), .run(run), .hi_len(hi_len), .lo_len(lo_len),
		.measure_pulse_input(pin));
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	// reference model: source cycles between effective pin edges, newest last
	// the capturing cycle restarts the count, so n cycles read back as n-1
	always @(posedge clk_sys) begin
		gap = gap + 1;
		if (pin !== pin_d && (meas_sel == ppw_pkg::PPW_WIDTH
				|| pin == (meas_sel == ppw_pkg::PPW_PER_RISE))) begin
			q_len.push_back(gap - 1);
			gap = 0;
		end
		pin_d = pin;
	end
	function automatic logic [15:0] nxt_rand(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task give_verdict;
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task tick(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	// bounded wait for a measurement interrupt
	task wait_irq;
		int i;
		for (i = 0; i < 300 && stat.irq_req !== 1'b1; i++) tick(1);
		if (stat.irq_req !== 1'b1) begin
			n_fail++;
			$display("wrong value at %0t: no capture interrupt in time", $time);
		end
	endtask
	initial begin
		{sys_rst, count_start, mode_wr, timer_wr, irq_ack, irq_clr_wr, run} = 7'h40;
		meas_sel = ppw_pkg::PPW_PER_FALL;
		src_sel = ppw_pkg::SRC_F1;
		fc32 = 1'b0;
		{timer_wdata, hi_len, lo_len, lfsr} = {16'h0, 16'ha, 16'ha, 16'h836d};
		tick(6);
		sys_rst = 1'b0;
		chk(16'({stat.ovf_flag, stat.irq_req}), 16'h0);
		// overflow from a cleared counter, no pulses
		count_start = 1'b1;
		tick(65530);
		chk(16'(stat.ovf_flag), 16'h0);
		tick(10);
		chk(16'({stat.ovf_flag, stat.irq_req}), 16'h3);
		count_start = 1'b0;
		mode_wr = 1'b1;
		tick(1);
		mode_wr = 1'b0;
		chk(16'(stat.ovf_flag), 16'h1);
		{count_start, mode_wr, irq_clr_wr} = 3'h7;
		tick(1);
		{count_start, mode_wr, irq_clr_wr} = 3'h0;
		tick(1);
		chk(16'({stat.ovf_flag, stat.irq_req}), 16'h0);
		// each measurement kind with random phase lengths
		// pass 3 repeats falling period on the external tick source
		for (int m = 0; m < 4; m++) begin
			lfsr = nxt_rand(lfsr);
			hi_len = 16'hc + {12'h0, lfsr[3:0]};
			lo_len = hi_len + 16'h5 + {13'h0, lfsr[6:4]};
			meas_sel = ppw_pkg::ppw_meas_t'(m % 3);
			{src_sel, fc32} = (m == 3) ? {ppw_pkg::SRC_FC32, 1'b1} : {ppw_pkg::SRC_F1, 1'b0};
			{count_start, run} = 2'h3;
			tick(int'(hi_len) + 4);
			chk(16'(stat.irq_req), 16'h0);
			for (int k = 0; k < 4; k++) begin
				wait_irq();
				keep = (m != 2) ? hi_len + lo_len - 16'h1 : ((k % 2) ? hi_len : lo_len) - 16'h1;
				chk(stat.result, keep);
				chk(stat.result, 16'(q_len[$]));
				{timer_wr, timer_wdata} = {1'b1, nxt_rand(lfsr)};
				{irq_ack, irq_clr_wr} = (k % 2) ? 2'h2 : 2'h1;
				tick(1);
				{timer_wr, irq_ack, irq_clr_wr} = 3'h0;
				tick(1);
				chk(16'(stat.irq_req), 16'h0);
			end
			count_start = 1'b0;
			tick(3 * int'(hi_len + lo_len));
			chk(stat.result, keep);
			chk(16'(stat.irq_req), 16'h0);
			run = 1'b0;
			tick(4);
		end
		give_verdict();
	end
endmodule
